//--- common/buf_usage_pkg.sv
// constants shared by the buffer manager register bank
package buf_usage_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int PORTS = 3;
   localparam int LIMIT_W = 8;
   localparam int PROB_W = 10;
   localparam int IDX_W = 4;
   localparam int TABLE_DEPTH = 16;
   localparam int BUFFER_BYTES = 128;
   // register numbers; one 32-bit word each
   localparam logic [15:0] FLOOD_LIMIT_OFS = 16'h1C04;
   localparam logic [15:0] PORT0_DROP_OFS = 16'h1C05;
   localparam logic [15:0] PORT1_DROP_OFS = 16'h1C06;
   localparam logic [15:0] PORT2_DROP_OFS = 16'h1C07;
   localparam logic [15:0] INIT_STATUS_OFS = 16'h1C08;
   localparam logic [15:0] TABLE_CMD_OFS = 16'h1C09;
   localparam logic [15:0] TABLE_WDATA_OFS = 16'h1C0A;
   localparam logic [15:0] TABLE_RDATA_OFS = 16'h1C0B;
   // field layout and reset values
   localparam logic [7:0] FLOOD_LIMIT_RST = 8'h31;
   localparam int CMD_DIR_BIT = 4;
   localparam int CMD_IDX_LSB = 0;
   localparam int CMD_W = 5;
   localparam logic [4:0] CMD_RST = 5'h00;
   localparam int READY_BIT = 0;
   localparam logic [9:0] PROB_RST = 10'h000;
   localparam logic [31:0] DROP_CNT_RST = 32'h0000_0000;
   localparam logic [31:0] DROP_CNT_MAX = 32'hFFFF_FFFF;
   localparam logic [9:0] LFSR_SEED = 10'h001;
   // buffer-usage bands of the discard table
   localparam logic [7:0] FINE_BAND_END = 8'h40;
   localparam logic [7:0] MID_BAND_END = 8'h80;
   localparam logic [1:0] MID_BAND_TAG = 2'h2;
   localparam logic [1:0] COARSE_BAND_TAG = 2'h3;
   // cycles spent initialising the lookup tables after a fabric reset
   localparam int INIT_CYCLES = 512;
endpackage

//--- rtl/drop_counter.sv
// saturating clear-on-read packet drop counter
`timescale 1ns/1ps
`default_nettype none
module drop_counter #(
   parameter int WIDTH = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [1:0] i_inc,
   input wire logic i_clear,
   output logic [WIDTH-1:0] o_count
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic [WIDTH:0] sum;

   if (WIDTH < 2) begin : g_check
      $error("drop_counter width too small");
   end

   always_comb begin
      // a drop in the clearing cycle survives the clear
      if (i_clear) begin
         sum = {{(WIDTH - 1){1'b0}}, i_inc};
      end else begin
         sum = {1'b0, count_reg} + {{(WIDTH - 1){1'b0}}, i_inc};
      end
      if (sum[WIDTH]) begin
         count_next = {WIDTH{1'b1}};
      end else begin
         count_next = sum[WIDTH-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   assign o_count = count_reg;
endmodule
`default_nettype wire

//--- rtl/discard_table.sv
// random-discard probability table with buffer-usage lookup
`timescale 1ns/1ps
`default_nettype none
module discard_table #(
   parameter int PROB_W = 10
) (
   input wire logic i_clk,
   input wire logic i_wr_en,
   input wire logic [3:0] i_wr_idx,
   input wire logic [PROB_W-1:0] i_wr_data,
   input wire logic [3:0] i_rd_idx,
   output logic [PROB_W-1:0] o_rd_data,
   input wire logic [7:0] i_usage,
   output logic [PROB_W-1:0] o_usage_prob
);
   // contents are not initialised on reset; software loads all entries
   logic [PROB_W-1:0] mem [buf_usage_pkg::TABLE_DEPTH];
   logic [3:0] usage_idx;

   if (PROB_W < 1) begin : g_check
      $error("discard_table entry width must be positive");
   end

   always_comb begin
      if (i_usage < buf_usage_pkg::FINE_BAND_END) begin
         usage_idx = {1'b0, i_usage[5:3]};
      end else if (i_usage < buf_usage_pkg::MID_BAND_END) begin
         usage_idx = {buf_usage_pkg::MID_BAND_TAG, i_usage[5:4]};
      end else begin
         usage_idx = {buf_usage_pkg::COARSE_BAND_TAG, i_usage[6:5]};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_wr_en) begin
         mem[i_wr_idx] <= i_wr_data;
      end
   end

   assign o_rd_data = mem[i_rd_idx];
   assign o_usage_prob = mem[usage_idx];
endmodule
`default_nettype wire

//--- rtl/switch_buffer_usage_regs.sv
// buffer manager usage registers: flood limit, drop counters, init flag, discard table
// How it works
// - 8-bit flood buffer limit, reset 31h, enforced
// - all limits and levels count 128-byte buffers
// - one 32-bit drop counter per ingress port
// - reading a drop counter clears it
// - drop counters saturate at all ones
// - ready flag low after fabric reset
// - ready flag self-sets, ignores software writes
// - each command write performs one table access
// - command bit 4: one reads, zero writes
// - read command loads entry into read data
// - bits 3:0 select one of sixteen entries
// - usage maps to fine, mid, coarse bands
// - discard probability chosen from port usage band
// - entry is yellow discard chance in 1/1024
// - yellow discard only while drop-on-yellow set
`timescale 1ns/1ps
`default_nettype none
module switch_buffer_usage_regs #(
   parameter int INIT_CYCLES = buf_usage_pkg::INIT_CYCLES,
   parameter int CNT_W = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   // register port
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // flood traffic buffer allocation
   input wire logic i_flood_alloc_req,
   input wire logic i_flood_buf_free,
   output logic o_flood_alloc_grant,
   output logic o_flood_limit_reached,
   // drops decided elsewhere in the datapath, one bit per port
   input wire logic [2:0] i_drop_event,
   // yellow packet discard decision
   input wire logic i_drop_on_yellow,
   input wire logic i_yellow_req,
   input wire logic [1:0] i_yellow_port,
   input wire logic [7:0] i_port0_usage,
   input wire logic [7:0] i_port1_usage,
   input wire logic [7:0] i_port2_usage,
   output logic o_yellow_discard,
   output logic o_yellow_keep,
   output logic o_table_init_done
);
   typedef enum logic [1:0] {
      INIT_RUN = 2'b01,
      INIT_DONE = 2'b10
   } init_state_e;

   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

   if (INIT_CYCLES < 1) begin : g_check_init
      $error("INIT_CYCLES must be at least one");
   end
   if (CNT_W < 2 || CNT_W > 32) begin : g_check_cnt
      $error("CNT_W must lie between 2 and 32");
   end

   // address decode
   logic hit_limit;
   logic hit_status;
   logic hit_cmd;
   logic hit_wdata;
   logic hit_rdata;
   logic [2:0] hit_drop;

   always_comb begin
      hit_limit = (i_reg_addr == buf_usage_pkg::FLOOD_LIMIT_OFS);
      hit_status = (i_reg_addr == buf_usage_pkg::INIT_STATUS_OFS);
      hit_cmd = (i_reg_addr == buf_usage_pkg::TABLE_CMD_OFS);
      hit_wdata = (i_reg_addr == buf_usage_pkg::TABLE_WDATA_OFS);
      hit_rdata = (i_reg_addr == buf_usage_pkg::TABLE_RDATA_OFS);
      hit_drop[0] = (i_reg_addr == buf_usage_pkg::PORT0_DROP_OFS);
      hit_drop[1] = (i_reg_addr == buf_usage_pkg::PORT1_DROP_OFS);
      hit_drop[2] = (i_reg_addr == buf_usage_pkg::PORT2_DROP_OFS);
   end

   // software-written configuration
   logic [7:0] limit_reg;
   logic [7:0] limit_next;
   logic [4:0] cmd_reg;
   logic [4:0] cmd_next;
   logic [9:0] wdata_reg;
   logic [9:0] wdata_next;
   logic [9:0] rdata_reg;
   logic [9:0] rdata_next;
   logic table_wr_en;
   logic table_rd_en;
   logic [9:0] table_rd_data;
   logic [3:0] cmd_idx;

   always_comb begin
      limit_next = limit_reg;
      cmd_next = cmd_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      table_wr_en = 1'b0;
      table_rd_en = 1'b0;
      cmd_idx = i_reg_wdata[buf_usage_pkg::CMD_IDX_LSB +: 4];
      if (i_reg_wr && hit_limit) begin
         limit_next = i_reg_wdata[7:0];
      end
      if (i_reg_wr && hit_wdata) begin
         wdata_next = i_reg_wdata[9:0];
      end
      if (i_reg_wr && hit_cmd) begin
         cmd_next = i_reg_wdata[buf_usage_pkg::CMD_W-1:0];
         if (i_reg_wdata[buf_usage_pkg::CMD_DIR_BIT]) begin
            table_rd_en = 1'b1;
         end else begin
            table_wr_en = 1'b1;
         end
      end
      if (table_rd_en) begin
         rdata_next = table_rd_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         limit_reg <= buf_usage_pkg::FLOOD_LIMIT_RST;
         cmd_reg <= buf_usage_pkg::CMD_RST;
         wdata_reg <= buf_usage_pkg::PROB_RST;
         rdata_reg <= buf_usage_pkg::PROB_RST;
      end else begin
         limit_reg <= limit_next;
         cmd_reg <= cmd_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
      end
   end

   // random discard table; an access finishes in the command write cycle
   logic [7:0] sel_usage;
   logic [9:0] usage_prob;

   always_comb begin
      unique case (i_yellow_port)
         2'h0: sel_usage = i_port0_usage;
         2'h1: sel_usage = i_port1_usage;
         2'h2: sel_usage = i_port2_usage;
         default: sel_usage = 8'h00;
      endcase
   end

   discard_table #(
      .PROB_W(buf_usage_pkg::PROB_W)
   ) u_table (
      .i_clk(i_clk),
      .i_wr_en(table_wr_en),
      .i_wr_idx(cmd_idx),
      .i_wr_data(wdata_reg),
      .i_rd_idx(cmd_idx),
      .o_rd_data(table_rd_data),
      .i_usage(sel_usage),
      .o_usage_prob(usage_prob)
   );

   // table initialisation after fabric reset
   init_state_e init_state_reg;
   init_state_e init_state_next;
   logic [INIT_W-1:0] init_cnt_reg;
   logic [INIT_W-1:0] init_cnt_next;

   always_comb begin
      init_state_next = init_state_reg;
      init_cnt_next = init_cnt_reg;
      unique case (init_state_reg)
         INIT_RUN: begin
            if (init_cnt_reg == INIT_LAST) begin
               init_state_next = INIT_DONE;
            end else begin
               init_cnt_next = init_cnt_reg + INIT_W'(1);
            end
         end
         INIT_DONE: begin
            init_state_next = INIT_DONE;
         end
         default: begin
            init_state_next = INIT_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         init_state_reg <= INIT_RUN;
         init_cnt_reg <= '0;
      end else begin
         init_state_reg <= init_state_next;
         init_cnt_reg <= init_cnt_next;
      end
   end

   // flood buffer occupancy against the limit
   logic [7:0] flood_used_reg;
   logic [7:0] flood_used_next;
   logic grant_reg;
   logic grant_next;
   logic full_reg;
   logic full_next;
   logic grant_now;
   logic free_now;

   always_comb begin
      grant_now = i_flood_alloc_req && (flood_used_reg < limit_reg);
      free_now = i_flood_buf_free && (flood_used_reg != 8'h00);
      flood_used_next = flood_used_reg;
      if (grant_now && !free_now) begin
         flood_used_next = flood_used_reg + 8'h01;
      end else if (free_now && !grant_now) begin
         flood_used_next = flood_used_reg - 8'h01;
      end
      grant_next = grant_now;
      full_next = (flood_used_next >= limit_next);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         flood_used_reg <= 8'h00;
         grant_reg <= 1'b0;
         full_reg <= 1'b0;
      end else begin
         flood_used_reg <= flood_used_next;
         grant_reg <= grant_next;
         full_reg <= full_next;
      end
   end

   // yellow packet random discard
   logic [9:0] lfsr_reg;
   logic [9:0] lfsr_next;
   logic discard_reg;
   logic discard_next;
   logic keep_reg;
   logic keep_next;
   logic [1:0] discard_port_reg;
   logic [1:0] discard_port_next;
   logic port_ok;

   always_comb begin
      lfsr_next = {lfsr_reg[8:0], lfsr_reg[9] ^ lfsr_reg[6]};
      port_ok = (i_yellow_port != 2'h3);
      discard_next = 1'b0;
      keep_next = 1'b0;
      discard_port_next = discard_port_reg;
      if (i_yellow_req && port_ok) begin
         discard_port_next = i_yellow_port;
         if (i_drop_on_yellow && (lfsr_reg < usage_prob)) begin
            discard_next = 1'b1;
         end else begin
            keep_next = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lfsr_reg <= buf_usage_pkg::LFSR_SEED;
         discard_reg <= 1'b0;
         keep_reg <= 1'b0;
         discard_port_reg <= 2'h0;
      end else begin
         lfsr_reg <= lfsr_next;
         discard_reg <= discard_next;
         keep_reg <= keep_next;
         discard_port_reg <= discard_port_next;
      end
   end

   // per-port drop counters
   logic [CNT_W-1:0] drop_count [3];

   for (genvar p = 0; p < 3; p++) begin : g_drop
      logic [1:0] inc;
      logic yellow_hit;
      always_comb begin
         yellow_hit = discard_reg && (discard_port_reg == 2'(p));
         inc = {1'b0, i_drop_event[p]} + {1'b0, yellow_hit};
      end
      drop_counter #(
         .WIDTH(CNT_W)
      ) u_cnt (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_inc(inc),
         .i_clear(i_reg_rd && hit_drop[p]),
         .o_count(drop_count[p])
      );
   end

   // register read path
   logic [31:0] rdata_out_reg;
   logic [31:0] rdata_out_next;
   logic rvalid_reg;
   logic rvalid_next;

   always_comb begin
      rdata_out_next = 32'h0000_0000;
      rvalid_next = i_reg_rd;
      if (i_reg_rd) begin
         if (hit_limit) begin
            rdata_out_next = {24'h000000, limit_reg};
         end else if (hit_drop[0]) begin
            rdata_out_next = 32'(drop_count[0]);
         end else if (hit_drop[1]) begin
            rdata_out_next = 32'(drop_count[1]);
         end else if (hit_drop[2]) begin
            rdata_out_next = 32'(drop_count[2]);
         end else if (hit_status) begin
            rdata_out_next = {31'h0, init_state_reg == INIT_DONE};
         end else if (hit_cmd) begin
            rdata_out_next = {27'h0, cmd_reg};
         end else if (hit_wdata) begin
            rdata_out_next = {22'h0, wdata_reg};
         end else if (hit_rdata) begin
            rdata_out_next = {22'h0, rdata_reg};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_out_reg <= 32'h0000_0000;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_out_reg <= rdata_out_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign o_reg_rdata = rdata_out_reg;
   assign o_reg_rvalid = rvalid_reg;
   assign o_flood_alloc_grant = grant_reg;
   assign o_flood_limit_reached = full_reg;
   assign o_yellow_discard = discard_reg;
   assign o_yellow_keep = keep_reg;
   // one-hot state: bit 1 is the done state, so the flag comes straight from a flop
   assign o_table_init_done = init_state_reg[1];
endmodule
`default_nettype wire

//--- dv/switch_buffer_usage_regs_props.sv
// concurrent checks on the buffer usage register bank ports
`timescale 1ns/1ps
`default_nettype none
module switch_buffer_usage_regs_props #(
   parameter int INIT_CYCLES = 4
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   input wire logic i_flood_alloc_req,
   input wire logic o_flood_alloc_grant,
   input wire logic i_drop_on_yellow,
   input wire logic i_yellow_req,
   input wire logic [1:0] i_yellow_port,
   input wire logic o_yellow_discard,
   input wire logic o_yellow_keep,
   input wire logic o_table_init_done
);
   int cnt_reg;
   int cnt_next;
   // edges seen since the last fabric reset, held at the init length
   always_comb begin
      cnt_next = cnt_reg;
      if (cnt_reg < INIT_CYCLES) begin
         cnt_next = cnt_reg + 1;
      end
   end
   always_ff @(posedge i_clk) begin
      cnt_reg <= i_rst ? 0 : cnt_next;
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_read;
      i_reg_rd;
   endsequence
   sequence s_answer;
      o_reg_rvalid;
   endsequence
   sequence s_status_read;
      i_reg_rd && i_reg_addr == buf_usage_pkg::INIT_STATUS_OFS;
   endsequence
   chk_read_answer: assert property (s_read |=> s_answer)
      else $error("read got no answer");
   chk_no_spurious: assert property (!i_reg_rd |=> !o_reg_rvalid)
      else $error("answer without read");
   chk_rdata_idle: assert property (!o_reg_rvalid |-> o_reg_rdata == 32'h0000_0000)
      else $error("read data not zero when idle");
   chk_status_bits: assert property (s_status_read |=> o_reg_rdata == {31'h0, $past(o_table_init_done)})
      else $error("status read differs from ready flag");
   chk_ready_time: assert property (o_table_init_done == (cnt_reg >= INIT_CYCLES))
      else $error("ready flag timing wrong");
   chk_ready_sticky: assert property (o_table_init_done |=> o_table_init_done)
      else $error("ready flag dropped");
   chk_limit_bits: assert property (i_reg_rd && i_reg_addr == buf_usage_pkg::FLOOD_LIMIT_OFS |=> o_reg_rdata[31:8] == 24'h0)
      else $error("limit reserved bits set");
   chk_grant_cause: assert property (o_flood_alloc_grant |-> $past(i_flood_alloc_req))
      else $error("grant without request");
   chk_yellow_answer: assert property (i_yellow_req && i_yellow_port != 2'h3 |=> o_yellow_discard != o_yellow_keep)
      else $error("yellow decision missing");
   chk_yellow_off: assert property (i_yellow_req && !i_drop_on_yellow |=> !o_yellow_discard)
      else $error("discard while disabled");
endmodule
bind switch_buffer_usage_regs switch_buffer_usage_regs_props #(.INIT_CYCLES(INIT_CYCLES)) props_u (
   .i_clk, .i_rst, .i_reg_addr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .i_flood_alloc_req,
   .o_flood_alloc_grant, .i_drop_on_yellow, .i_yellow_req, .i_yellow_port, .o_yellow_discard,
   .o_yellow_keep, .o_table_init_done
);
`default_nettype wire

//--- dv/switch_buffer_usage_regs_bench.sv
// self-checking bench for the buffer usage register bank
`timescale 1ns/1ps
`default_nettype none
module switch_buffer_usage_regs_bench;
   localparam int CW = 4;
   localparam int MX = (1 << CW) - 1;
   localparam logic [15:0] LIM = buf_usage_pkg::FLOOD_LIMIT_OFS;
   localparam logic [15:0] ST = buf_usage_pkg::INIT_STATUS_OFS;
   localparam logic [15:0] CMD = buf_usage_pkg::TABLE_CMD_OFS;
   localparam logic [15:0] DRP = buf_usage_pkg::PORT0_DROP_OFS;
   logic i_clk = '0, i_rst = '1, i_reg_wr = '0, i_reg_rd = '0;
   logic i_flood_alloc_req = '0, i_flood_buf_free = '0, i_drop_on_yellow = '0, i_yellow_req = '0;
   logic [15:0] i_reg_addr = '0;
   logic [31:0] i_reg_wdata = '0, o_reg_rdata;
   logic [2:0] i_drop_event = '0;
   logic [1:0] i_yellow_port = '0, ye;
   logic [7:0] us[3] = '{default: '0};
   logic o_reg_rvalid, o_flood_alloc_grant, o_flood_limit_reached;
   logic o_yellow_discard, o_yellow_keep, o_table_init_done;
   int error_cnt = 0, compares = 0, seed = 16, disc = 0, grants = 0, n;
   int cnt[3];
   logic [31:0] rd_q[$];
   logic [1:0] y_q[$];
   logic [9:0] tbl[16];
   switch_buffer_usage_regs #(.INIT_CYCLES(4), .CNT_W(CW)) dut_u (
      .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .o_reg_rvalid(o_reg_rvalid), .i_flood_alloc_req(i_flood_alloc_req),
      .i_flood_buf_free(i_flood_buf_free), .o_flood_alloc_grant(o_flood_alloc_grant),
      .o_flood_limit_reached(o_flood_limit_reached), .i_drop_event(i_drop_event),
      .i_drop_on_yellow(i_drop_on_yellow), .i_yellow_req(i_yellow_req),
      .i_yellow_port(i_yellow_port), .i_port0_usage(us[0]), .i_port1_usage(us[1]),
      .i_port2_usage(us[2]), .o_yellow_discard(o_yellow_discard),
      .o_yellow_keep(o_yellow_keep), .o_table_init_done(o_table_init_done)
   );
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'h1;
      @(negedge i_clk);
      i_reg_wr = 1'h0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(negedge i_clk);
      i_reg_addr = a;
      i_reg_rd = 1'h1;
      rd_q.push_back(e);
      @(negedge i_clk);
      i_reg_rd = 1'h0;
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clk);
      s = 1'h1;
      @(negedge i_clk);
      s = 1'h0;
   endtask
   // e: 0 keep, 1 discard, 2 either; other ports sit in a band that would decide otherwise
   task automatic yel(input logic [1:0] p, input logic [7:0] u, input logic [1:0] e);
      @(negedge i_clk);
      us = '{3{(e == 2'h0) ? 8'h50 : ~u}};
      i_yellow_port = p;
      i_yellow_req = 1'h1;
      if (p != 2'h3) begin
         us[p] = u;
         y_q.push_back(e);
      end
      @(negedge i_clk);
      i_yellow_req = 1'h0;
   endtask
   // outputs are sampled mid-cycle, away from the edge that launches them
   always @(negedge i_clk) begin
      if (o_reg_rvalid) begin
         chk(o_reg_rdata, rd_q.pop_front());
      end
      if (o_yellow_discard || o_yellow_keep) begin
         chk(y_q.size() > 0, 1'h1);
         ye = y_q.pop_front();
         disc += o_yellow_discard;
         if (ye < 2'h2) chk(o_yellow_discard, ye);
      end
      if (o_flood_alloc_grant) grants++;
   end
   initial begin
      repeat (3) @(negedge i_clk);
      i_rst = 1'h0;
      rd(ST, 32'h0);
      rd(LIM, 32'h31);
      for (n = 0; n < 20 && o_table_init_done !== 1'h1; n++) @(negedge i_clk);
      chk(o_table_init_done, 1'h1);
      wr(ST, 32'h0);
      rd(ST, 32'h1);
      for (int p = 0; p < 3; p++) rd(DRP + p, 32'h0);
      rd(16'h1C0F, 32'h0);
      $display("reset values done");
      for (int i = 0; i < 16; i++) begin
         tbl[i] = $random(seed);
         wr(buf_usage_pkg::TABLE_WDATA_OFS, {22'h0, tbl[i]});
         wr(CMD, i);
      end
      for (int i = 0; i < 16; i++) begin
         wr(CMD, 32'h10 | i);
         rd(buf_usage_pkg::TABLE_RDATA_OFS, {22'h0, tbl[i]});
      end
      rd(CMD, 32'h1F);
      $display("table access done");
      for (int i = 0; i < 16; i++) begin
         wr(buf_usage_pkg::TABLE_WDATA_OFS, (i == 9) ? 32'h3FF : 32'h0);
         wr(CMD, i);
      end
      i_drop_on_yellow = 1'h1;
      for (int k = 0; k < 4; k++) begin
         yel(k % 3, 8'h4F, 2'h0);
         yel(k % 3, 8'h60, 2'h0);
         yel(2'h2, 8'h50, 2'h2);
         yel(2'h2, 8'h5F, 2'h2);
      end
      yel(2'h3, 8'h50, 2'h0);
      i_drop_on_yellow = 1'h0;
      yel(2'h2, 8'h50, 2'h0);
      @(negedge i_clk);
      chk(disc >= 7, 1'h1);
      rd(DRP + 2, disc);
      rd(DRP, 32'h0);
      $display("yellow discard done");
      cnt = '{0, 0, 0};
      repeat (24) begin
         @(negedge i_clk);
         i_drop_event = $random(seed) | $random(seed);
         for (int p = 0; p < 3; p++) cnt[p] += i_drop_event[p];
      end
      @(negedge i_clk);
      i_drop_event = 3'h0;
      for (int p = 0; p < 3; p++) begin
         rd(DRP + p, (cnt[p] > MX) ? MX : cnt[p]);
         rd(DRP + p, 32'h0);
      end
      $display("drop counters done");
      wr(LIM, 32'h102);
      rd(LIM, 32'h2);
      repeat (3) pulse(i_flood_alloc_req);
      repeat (2) @(negedge i_clk);
      chk(grants, 2);
      chk(o_flood_limit_reached, 1'h1);
      pulse(i_flood_buf_free);
      chk(o_flood_limit_reached, 1'h0);
      pulse(i_flood_alloc_req);
      repeat (2) @(negedge i_clk);
      chk(grants, 3);
      $display("flood limit done");
      i_rst = 1'h1;
      @(negedge i_clk);
      i_rst = 1'h0;
      rd(ST, 32'h0);
      rd(LIM, 32'h31);
      repeat (3) @(negedge i_clk);
      chk(rd_q.size() + y_q.size(), 0);
      $display("second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
